// *** uwb_pkg.sv ***
// Constants for the upstream memory window base registers of the bridge.
// Assumes a 32-bit Avalon-MM slave with a byte address and one word per register.
package uwb_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [8:0] WIDE_SETUP_LO_OFS = 9'h034;
    localparam logic [8:0] WIDE_SETUP_HI_OFS = 9'h038;
    localparam logic [8:0] PAGED_BASE_OFS = 9'h05C;
    localparam logic [8:0] WIDE_BASE_LO_OFS = 9'h060;
    localparam logic [8:0] WIDE_BASE_HI_OFS = 9'h064;
    localparam logic [8:0] FWD_CTRL_OFS = 9'h068;
    localparam logic [8:0] PAGE_TABLE_OFS = 9'h100;

    // ------------------------------------------------------------
    // Field positions and codes
    // ------------------------------------------------------------
    localparam int FWD_PAGE_LSB = 16;
    localparam int FWD_PAGE_MSB = 19;
    localparam int FWD_ADDR64_BIT = 21;
    localparam int SETUP_EN_BIT = 31;
    localparam int TYPE_LSB = 1;
    localparam int TYPE_MSB = 2;
    localparam int PREFETCH_BIT = 3;
    localparam int PAGE_COUNT = 64;
    localparam int PAGE_SHIFT_BASE = 7;
    localparam int WINDOW_SHIFT_BASE = 13;
    localparam logic [31:0] WIDE_LO_BASE_MASK = 32'hFFFF_F000;
    localparam logic [31:0] FWD_CTRL_WMASK = 32'h002F_0000;
    localparam logic [1:0] TYPE_32 = 2'h0;
    localparam logic [1:0] TYPE_64 = 2'h1;
    localparam logic [3:0] PAGE_CODE_OFF = 4'h0;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [31:0] BASE_RESET = 32'h0000_0000;
    localparam logic [31:0] SETUP_RESET = 32'h0000_0000;
    localparam logic [31:0] FWD_CTRL_RESET = 32'h0000_0000;
    localparam logic [63:0] PAGE_TABLE_RESET = 64'h0000_0000_0000_0000;

endpackage : uwb_pkg

// *** uwb_match.sv ***
// Masked address comparator for one upstream window.
// Assumes base and mask are already cut to the writable bits of the window.
`timescale 1ns/1ps
`default_nettype none
module uwb_match #(
    parameter int W = 64
) (
    input wire logic [W-1:0] base_i,
    input wire logic [W-1:0] mask_i,
    input wire logic [W-1:0] addr_i,
    input wire logic enable_i,
    output logic hit_o
);

    // Only masked bits take part; bits below the window size are ignored
    assign hit_o = enable_i && (|mask_i) && (((addr_i ^ base_i) & mask_i) == '0);

endmodule : uwb_match
`default_nettype wire

// *** uwb_windows.sv ***
// Upstream paged and wide window base registers with their address decode.
// Assumes a 32-bit Avalon-MM master and a transaction source on the same clock.
`timescale 1ns/1ps
`default_nettype none
module uwb_windows (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic [8:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic txn_valid_i,
    input wire logic [63:0] txn_addr_i,
    input wire logic txn_dual_addr_i,
    input wire logic txn_down_hit_i,
    output logic paged_hit_o,
    output logic [5:0] paged_page_o,
    output logic wide_hit_o,
    output logic wide_xlate_o,
    output logic fwd_upstream_o
);

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------

    // Merge write data into a register by byte lane and writable mask
    function automatic logic [31:0] be_merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0] be,
        input logic [31:0] wmask
    );
        logic [31:0] lane;
        lane = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wmask;
        be_merge = (old_v & ~lane) | (new_v & lane);
    endfunction : be_merge

    // Writable base mask of the paged window for a page size code
    function automatic logic [31:0] paged_mask(input logic [3:0] code);
        if (code == uwb_pkg::PAGE_CODE_OFF)
        begin
            paged_mask = 32'h0000_0000;
        end
        else
        begin
            paged_mask = 32'hFFFF_FFFF << (uwb_pkg::WINDOW_SHIFT_BASE + int'(code));
        end
    endfunction : paged_mask

    // Page index inside the paged window
    function automatic logic [5:0] page_of(input logic [31:0] a, input logic [3:0] code);
        logic [31:0] s;
        s = a >> (uwb_pkg::PAGE_SHIFT_BASE + int'(code));
        page_of = s[5:0];
    endfunction : page_of

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic ack_reg;
    logic [31:0] readdata_reg;
    logic [31:0] paged_base_reg;
    logic [31:0] wide_lo_reg;
    logic [31:0] wide_hi_reg;
    logic [31:0] setup_lo_reg;
    logic [31:0] setup_hi_reg;
    logic [31:0] fwd_ctrl_reg;
    logic [uwb_pkg::PAGE_COUNT-1:0] page_en_reg;
    logic paged_hit_reg;
    logic [5:0] paged_page_reg;
    logic wide_hit_reg;
    logic wide_xlate_reg;
    logic fwd_reg;

    logic bus_req;
    logic wr_go;
    logic [8:0] word_addr;
    logic [3:0] page_code;
    logic addr64_en;
    logic wide64;
    logic [31:0] pmask;
    logic [31:0] lo_wmask;
    logic [31:0] hi_wmask;
    logic [31:0] rd_value;
    logic paged_match;
    logic wide_match;
    logic [5:0] page_c;
    logic page_sel_en;
    logic paged_hit_c;
    logic wide_hit_c;
    logic dual_out_c;

    // ------------------------------------------------------------
    // Configuration decode
    // ------------------------------------------------------------

    // Fields of the forwarding control and setup registers
    assign page_code = fwd_ctrl_reg[uwb_pkg::FWD_PAGE_MSB:uwb_pkg::FWD_PAGE_LSB];
    assign addr64_en = fwd_ctrl_reg[uwb_pkg::FWD_ADDR64_BIT];
    assign pmask = paged_mask(page_code);
    assign wide64 = addr64_en && (setup_lo_reg[uwb_pkg::TYPE_MSB:uwb_pkg::TYPE_LSB] == uwb_pkg::TYPE_64);
    assign lo_wmask = setup_lo_reg[uwb_pkg::SETUP_EN_BIT]
        ? (setup_lo_reg & uwb_pkg::WIDE_LO_BASE_MASK) : 32'h0000_0000;
    assign hi_wmask = (setup_lo_reg[uwb_pkg::SETUP_EN_BIT] && setup_hi_reg[uwb_pkg::SETUP_EN_BIT])
        ? setup_hi_reg : 32'h0000_0000;

    // ------------------------------------------------------------
    // Avalon-MM slave
    // ------------------------------------------------------------

    // Every access waits one cycle, then completes with waitrequest low
    assign bus_req = avs_read_i || avs_write_i;
    assign avs_waitrequest_o = bus_req && !ack_reg;
    assign wr_go = avs_write_i && ack_reg;
    assign word_addr = {avs_address_i[8:2], 2'h0};
    assign avs_readdata_o = readdata_reg;

    // Acknowledge flag, high in the completing cycle only
    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            ack_reg <= 1'h0;
        end
        else
        begin
            ack_reg <= bus_req && !ack_reg;
        end
    end

    // Read mux; unmapped words read as zero
    always_comb
    begin
        rd_value = 32'h0000_0000;
        if (avs_address_i[8])
        begin
            rd_value = {31'h0000_0000, page_en_reg[avs_address_i[7:2]]};
        end
        else
        begin
            case (word_addr)
                uwb_pkg::WIDE_SETUP_LO_OFS: rd_value = setup_lo_reg;
                uwb_pkg::WIDE_SETUP_HI_OFS: rd_value = setup_hi_reg;
                uwb_pkg::PAGED_BASE_OFS: rd_value = paged_base_reg & pmask;
                uwb_pkg::WIDE_BASE_LO_OFS: rd_value = (wide_lo_reg & lo_wmask) | {28'h000_0000,
                    setup_lo_reg[uwb_pkg::PREFETCH_BIT], setup_lo_reg[uwb_pkg::TYPE_MSB:uwb_pkg::TYPE_LSB], 1'h0};
                uwb_pkg::WIDE_BASE_HI_OFS: rd_value = wide_hi_reg & hi_wmask;
                uwb_pkg::FWD_CTRL_OFS: rd_value = fwd_ctrl_reg;
                default: rd_value = 32'h0000_0000;
            endcase
        end
    end

    // Read data captured in the waiting cycle, stands through completion
    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            readdata_reg <= 32'h0000_0000;
        end
        else if (avs_read_i && !ack_reg)
        begin
            readdata_reg <= rd_value;
        end
    end

    // ------------------------------------------------------------
    // Setup and control registers
    // ------------------------------------------------------------

    // Wide window low setup, written over the Avalon-MM slave
    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            setup_lo_reg <= uwb_pkg::SETUP_RESET;
        end
        else if (wr_go && word_addr == uwb_pkg::WIDE_SETUP_LO_OFS && !avs_address_i[8])
        begin
            setup_lo_reg <= be_merge(setup_lo_reg, avs_writedata_i, avs_byteenable_i, 32'hFFFF_FFFF);
        end
    end

    // Wide window upper setup, written over the Avalon-MM slave
    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            setup_hi_reg <= uwb_pkg::SETUP_RESET;
        end
        else if (wr_go && word_addr == uwb_pkg::WIDE_SETUP_HI_OFS && !avs_address_i[8])
        begin
            setup_hi_reg <= be_merge(setup_hi_reg, avs_writedata_i, avs_byteenable_i, 32'hFFFF_FFFF);
        end
    end

    // Forwarding control: page size code and 64-bit enable
    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            fwd_ctrl_reg <= uwb_pkg::FWD_CTRL_RESET;
        end
        else if (wr_go && word_addr == uwb_pkg::FWD_CTRL_OFS && !avs_address_i[8])
        begin
            fwd_ctrl_reg <= be_merge(fwd_ctrl_reg, avs_writedata_i, avs_byteenable_i, uwb_pkg::FWD_CTRL_WMASK);
        end
    end

    // Page enable table, one bit per page entry
    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            page_en_reg <= uwb_pkg::PAGE_TABLE_RESET;
        end
        else if (wr_go && avs_address_i[8] && avs_byteenable_i[0])
        begin
            page_en_reg[avs_address_i[7:2]] <= avs_writedata_i[0];
        end
    end

    // ------------------------------------------------------------
    // Base address registers
    // ------------------------------------------------------------

    // Paged window base, writable bits set by page size
    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            paged_base_reg <= uwb_pkg::BASE_RESET;
        end
        else if (wr_go && word_addr == uwb_pkg::PAGED_BASE_OFS && !avs_address_i[8])
        begin
            paged_base_reg <= be_merge(paged_base_reg, avs_writedata_i, avs_byteenable_i, pmask);
        end
    end

    // Wide window low base, writable bits from low setup
    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            wide_lo_reg <= uwb_pkg::BASE_RESET;
        end
        else if (wr_go && word_addr == uwb_pkg::WIDE_BASE_LO_OFS && !avs_address_i[8])
        begin
            wide_lo_reg <= be_merge(wide_lo_reg, avs_writedata_i, avs_byteenable_i, lo_wmask);
        end
    end

    // Wide window upper base, writable bits from upper setup
    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            wide_hi_reg <= uwb_pkg::BASE_RESET;
        end
        else if (wr_go && word_addr == uwb_pkg::WIDE_BASE_HI_OFS && !avs_address_i[8])
        begin
            wide_hi_reg <= be_merge(wide_hi_reg, avs_writedata_i, avs_byteenable_i, hi_wmask);
        end
    end

    // ------------------------------------------------------------
    // Window decode
    // ------------------------------------------------------------

    // Paged window: 32-bit only, upper address must be zero
    uwb_match #(
        .W(64)
    ) u_paged_match (
        .base_i({32'h0000_0000, paged_base_reg & pmask}),
        .mask_i({32'hFFFF_FFFF, pmask}),
        .addr_i(txn_addr_i),
        .enable_i(page_code != uwb_pkg::PAGE_CODE_OFF),
        .hit_o(paged_match)
    );

    // Wide window: 64-bit compare only when combined, else 32-bit
    uwb_match #(
        .W(64)
    ) u_wide_match (
        .base_i(wide64 ? {wide_hi_reg & hi_wmask, wide_lo_reg & lo_wmask} : {32'h0000_0000, wide_lo_reg & lo_wmask}),
        .mask_i(wide64 ? {hi_wmask, lo_wmask} : {32'hFFFF_FFFF, lo_wmask}),
        .addr_i(txn_addr_i),
        .enable_i(setup_lo_reg[uwb_pkg::SETUP_EN_BIT]),
        .hit_o(wide_match)
    );

    // Page lookup and forwarding decisions
    assign page_c = page_of(txn_addr_i[31:0], page_code);
    assign page_sel_en = page_en_reg[page_c];
    assign paged_hit_c = txn_valid_i && paged_match && page_sel_en;
    assign wide_hit_c = txn_valid_i && wide_match;
    assign dual_out_c = txn_valid_i && txn_dual_addr_i && !txn_down_hit_i;

    // Registered decode results, one cycle after the address
    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            paged_hit_reg <= 1'h0;
            paged_page_reg <= 6'h00;
            wide_hit_reg <= 1'h0;
            wide_xlate_reg <= 1'h0;
            fwd_reg <= 1'h0;
        end
        else
        begin
            paged_hit_reg <= paged_hit_c;
            paged_page_reg <= paged_hit_c ? page_c : 6'h00;
            wide_hit_reg <= wide_hit_c;
            wide_xlate_reg <= wide_hit_c && wide64;
            fwd_reg <= paged_hit_c || wide_hit_c || dual_out_c;
        end
    end

    assign paged_hit_o = paged_hit_reg;
    assign paged_page_o = paged_page_reg;
    assign wide_hit_o = wide_hit_reg;
    assign wide_xlate_o = wide_xlate_reg;
    assign fwd_upstream_o = fwd_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);

    sequence s_req_wait;
        bus_req && avs_waitrequest_o;
    endsequence

    sequence s_rd_done;
        avs_read_i && !avs_waitrequest_o;
    endsequence

    property p_one_wait;
        s_req_wait ##1 bus_req |-> !avs_waitrequest_o;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("access not answered after one wait");

    property p_paged_low_zero;
        s_rd_done ##0 (word_addr == uwb_pkg::PAGED_BASE_OFS) && !avs_address_i[8]
            |-> (avs_readdata_o & ~$past(pmask)) == 32'h0000_0000;
    endproperty
    a_paged_low_zero: assert property (p_paged_low_zero) else $error("paged base low bits not zero");

    property p_wide_ro_zero;
        s_rd_done ##0 (word_addr == uwb_pkg::WIDE_BASE_LO_OFS) && !avs_address_i[8]
            |-> (avs_readdata_o & uwb_pkg::WIDE_LO_BASE_MASK & ~$past(lo_wmask)) == 32'h0000_0000;
    endproperty
    a_wide_ro_zero: assert property (p_wide_ro_zero) else $error("wide base fixed bit reads one");

    property p_page_enable;
        paged_hit_o |-> $past(page_sel_en) && paged_page_o == $past(page_c);
    endproperty
    a_page_enable: assert property (p_page_enable) else $error("disabled page claimed");

    property p_page_off;
        paged_hit_o |-> $past(page_code) != uwb_pkg::PAGE_CODE_OFF;
    endproperty
    a_page_off: assert property (p_page_off) else $error("paged hit with window off");

    property p_xlate_64;
        wide_xlate_o |-> wide_hit_o && $past(wide64);
    endproperty
    a_xlate_64: assert property (p_xlate_64) else $error("translation without 64-bit mode");

    property p_dual_forward;
        txn_valid_i && txn_dual_addr_i && !txn_down_hit_i |=> fwd_upstream_o;
    endproperty
    a_dual_forward: assert property (p_dual_forward) else $error("64-bit transaction not forwarded");

    property p_wide_disable;
        wide_hit_o |-> $past(setup_lo_reg[uwb_pkg::SETUP_EN_BIT]);
    endproperty
    a_wide_disable: assert property (p_wide_disable) else $error("disabled wide window claimed");

    property p_upper_needs_64;
        wide_hit_o && $past(txn_addr_i[63:32]) != 32'h0000_0000 |-> $past(wide64);
    endproperty
    a_upper_needs_64: assert property (p_upper_needs_64) else $error("upper address hit in 32-bit mode");

endmodule : uwb_windows
`default_nettype wire

// *** uwb_txn_source.sv ***
// Model of a secondary-side bus master presenting transaction addresses.
// Assumes the bench requests one address at a time on the core clock.
`timescale 1ns/1ps
`default_nettype none
module uwb_txn_source (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic go_i,
    input wire logic [63:0] addr_i,
    input wire logic dual_i,
    input wire logic down_i,
    output logic txn_valid_o,
    output logic [63:0] txn_addr_o,
    output logic txn_dual_addr_o,
    output logic txn_down_hit_o
);
    // ------------------------------------------------------------
    // Address phase
    // ------------------------------------------------------------
    // One cycle per address; released lines toggle so stale values never match
    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            txn_valid_o <= 1'b0;
            txn_addr_o <= 64'h0000_0000_0000_0000;
            txn_dual_addr_o <= 1'b0;
            txn_down_hit_o <= 1'b0;
        end
        else
        begin
            txn_valid_o <= go_i;
            txn_addr_o <= go_i ? addr_i : ~txn_addr_o;
            txn_dual_addr_o <= go_i ? dual_i : ~txn_dual_addr_o;
            txn_down_hit_o <= go_i ? down_i : ~txn_down_hit_o;
        end
    end
endmodule : uwb_txn_source
`default_nettype wire

// *** uwb_windows_tb.sv ***
// Self-checking bench for the upstream window base registers and decode.
// Assumes the Avalon slave answers after its wait cycle and the model drives transactions.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module uwb_windows_tb;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [8:0] avs_address = 9'h000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o;
    logic go = 1'b0;
    logic [63:0] t_addr = 64'h0000_0000_0000_0000;
    logic t_dual = 1'b0;
    logic t_down = 1'b0;
    logic txn_valid;
    logic [63:0] txn_addr;
    logic txn_dual;
    logic txn_down;
    logic paged_hit;
    logic [5:0] paged_page;
    logic wide_hit;
    logic wide_xlate;
    logic fwd_up;
    logic [9:0] seen;
    logic [63:0] ra = 64'h0000_0000_0000_0000;
    logic [3:0] code = 4'h0;
    logic [31:0] pbase = 32'h0000_0000;
    logic [63:0] ptab = 64'h0000_0000_0000_0000;
    logic [31:0] seed = 32'h0000_94D9;
    int n_fail = 0;
    int n_compared = 0;

    // ------------------------------------------------------------
    // Clock, design and partner
    // ------------------------------------------------------------
    // Clock of 100 ns period
    always #50 core_clk = ~core_clk;

    uwb_windows uwb_windows_inst (.core_clk_i(core_clk), .reset_i(rst), .avs_address_i(avs_address),
        .avs_read_i(avs_read), .avs_write_i(avs_write), .avs_writedata_i(avs_writedata),
        .avs_byteenable_i(4'hF), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .txn_valid_i(txn_valid), .txn_addr_i(txn_addr), .txn_dual_addr_i(txn_dual),
        .txn_down_hit_i(txn_down), .paged_hit_o(paged_hit), .paged_page_o(paged_page),
        .wide_hit_o(wide_hit), .wide_xlate_o(wide_xlate), .fwd_upstream_o(fwd_up));

    // Decode outputs gathered into one vector for comparison
    assign seen = {paged_hit, paged_page, wide_hit, wide_xlate, fwd_up};

    uwb_txn_source uwb_txn_source_inst (.core_clk_i(core_clk), .reset_i(rst), .go_i(go), .addr_i(t_addr),
        .dual_i(t_dual), .down_i(t_down), .txn_valid_o(txn_valid), .txn_addr_o(txn_addr),
        .txn_dual_addr_o(txn_dual), .txn_down_hit_o(txn_down));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Verdict and end of run
    task report_and_stop();
        if (n_fail == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : report_and_stop

    // Xorshift step for repeatable random values
    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        begin
            y = x ^ (x << 13);
            y = y ^ (y >> 17);
            xs = y ^ (y << 5);
        end
    endfunction : xs

    // Expected decode outputs with the wide window off
    function automatic logic [9:0] exp_vec(input logic [63:0] a);
        logic [31:0] m;
        logic [5:0] p;
        logic h;
        begin
            m = 32'hFFFF_FFFF << (13 + code);
            p = 6'(a[31:0] >> (7 + code));
            h = (code != 4'h0) && (a[63:32] == 32'h0000_0000) && ((a[31:0] & m) == (pbase & m)) && ptab[p];
            exp_vec = {h, h ? p : 6'h00, 2'b00, h};
        end
    endfunction : exp_vec

    // One Avalon transfer held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [8:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge core_clk);
        while (avs_waitrequest_o !== 1'b0)
        begin
            @(posedge core_clk);
        end
        q = avs_readdata_o;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus

    // Register write
    task automatic wr(input logic [8:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    // Register read and compare
    task automatic rd(input logic [8:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, q);
        `CHK("readdata", e, q)
    endtask : rd

    // One transaction address, decode checked one cycle after it
    task automatic txn(input logic [63:0] a, input logic d, input logic dn, input logic [9:0] e);
        @(posedge core_clk);
        go <= 1'b1;
        t_addr <= a;
        t_dual <= d;
        t_down <= dn;
        @(posedge core_clk);
        go <= 1'b0;
        @(posedge core_clk);
        @(negedge core_clk);
        `CHK("decode", e, seen)
    endtask : txn

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    // Reset, then register and decode scenarios
    initial
    begin
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        rd(uwb_pkg::PAGED_BASE_OFS, 32'h0000_0000);
        rd(uwb_pkg::WIDE_BASE_LO_OFS, 32'h0000_0000);
        rd(uwb_pkg::WIDE_BASE_HI_OFS, 32'h0000_0000);
        wr(9'h0F0, 32'hFFFF_FFFF);
        rd(9'h0F0, 32'h0000_0000);
        wr(uwb_pkg::FWD_CTRL_OFS, 32'hFFFF_FFFF);
        rd(uwb_pkg::FWD_CTRL_OFS, 32'h002F_0000);
        wr(uwb_pkg::FWD_CTRL_OFS, 32'h0000_0000);
        wr(uwb_pkg::PAGED_BASE_OFS, 32'hFFFF_FFFF);
        rd(uwb_pkg::PAGED_BASE_OFS, 32'h0000_0000);
        txn(64'h0000_0000_0000_0000, 1'b0, 1'b0, exp_vec(64'h0000_0000_0000_0000));
        for (int c = 1; c <= 4; c++)
        begin
            wr(uwb_pkg::FWD_CTRL_OFS, 32'(c) << 16);
            wr(uwb_pkg::PAGED_BASE_OFS, 32'hFFFF_FFFF);
            rd(uwb_pkg::PAGED_BASE_OFS, 32'hFFFF_FFFF << (13 + c));
        end
        code = 4'h2;
        wr(uwb_pkg::FWD_CTRL_OFS, 32'h0002_0000);
        seed = xs(seed);
        pbase = seed & (32'hFFFF_FFFF << 15);
        wr(uwb_pkg::PAGED_BASE_OFS, pbase);
        for (int i = 0; i < 64; i++)
        begin
            seed = xs(seed);
            ptab[i] = seed[0];
            wr(uwb_pkg::PAGE_TABLE_OFS + 9'(4 * i), {31'h0000_0000, seed[0]});
        end
        for (int i = 0; i < 48; i++)
        begin
            seed = xs(seed);
            ra = {32'h0000_0000, seed[31] ? seed : (pbase | (seed & 32'h0000_7FFF))};
            txn(ra, 1'b0, 1'b0, exp_vec(ra));
        end
        ptab[5] = 1'b0;
        wr(uwb_pkg::PAGE_TABLE_OFS + 9'h014, 32'h0000_0000);
        txn({32'h0000_0000, pbase | 32'h0000_0A00}, 1'b0, 1'b0, {7'h00, 3'b000});
        code = 4'h0;
        wr(uwb_pkg::FWD_CTRL_OFS, 32'h0020_0000);
        wr(uwb_pkg::WIDE_SETUP_LO_OFS, 32'hFFFF_F002);
        wr(uwb_pkg::WIDE_SETUP_HI_OFS, 32'hFFFF_FFFF);
        wr(uwb_pkg::WIDE_BASE_LO_OFS, 32'h1234_5FFF);
        rd(uwb_pkg::WIDE_BASE_LO_OFS, 32'h1234_5002);
        wr(uwb_pkg::WIDE_BASE_HI_OFS, 32'h0000_00AB);
        rd(uwb_pkg::WIDE_BASE_HI_OFS, 32'h0000_00AB);
        txn(64'h0000_00AB_1234_5678, 1'b1, 1'b0, {7'h00, 3'b111});
        txn(64'h0000_00AC_1234_5678, 1'b1, 1'b0, {7'h00, 3'b001});
        txn(64'h0000_00AC_1234_5678, 1'b1, 1'b1, {7'h00, 3'b000});
        wr(uwb_pkg::FWD_CTRL_OFS, 32'h0000_0000);
        txn(64'h0000_0000_1234_5FF0, 1'b0, 1'b0, {7'h00, 3'b101});
        txn(64'h0000_00AB_1234_5678, 1'b0, 1'b0, {7'h00, 3'b000});
        wr(uwb_pkg::WIDE_SETUP_LO_OFS, 32'h7FFF_F002);
        txn(64'h0000_0000_1234_5678, 1'b0, 1'b0, {7'h00, 3'b000});
        report_and_stop();
    end

    // Watchdog well beyond the expected run length
    initial
    begin
        #500_000;
        n_fail++;
        report_and_stop();
    end
endmodule : uwb_windows_tb
`default_nettype wire
